// File: dv/test_usb_charger_detect_control.sv
// self-checking bench for the charger detect control block
`timescale 1ns/1ps
module test_usb_charger_detect_control;
  logic i_clk = 1'b0, i_reset_n, i_wr_en, i_adc_always_on, i_bus_valid;
  logic i_usb_compliant_sel, i_charger_enable_force, i_force_value;
  logic i_bus_above_det, i_contact_ok, i_type_valid, contact_en;
  logic i_data_pos_switch_req, i_data_neg_switch_req, o_data_pos_switch;
  logic o_data_neg_switch, o_src_on, o_weak_pullup, o_short_test, o_adc_on;
  logic o_ovp_closed, o_ovp_logic, o_ce_n_out, o_ce_n_oe_n, o_busy;
  logic o_contact_detect_timeout_flag;
  logic [7:0] i_addr, i_wdata, o_rdata, expq[$];
  logic [3:0] i_type_code, o_detected_port_type, code_r;
  logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                           4'hc};
  int mismatches, samples_checked;
  wire flag = o_contact_detect_timeout_flag;
  wire [7:0] res = {o_detected_port_type, o_ce_n_oe_n, o_data_pos_switch,
                    o_data_neg_switch, o_rdata[1]};
  always #5 i_clk = ~i_clk; // 100 MHz
  ucd_ctrl #(.DCD_TIMEOUT_CYC(20), .SRC_SHORT_CYC(5), .SRC_LONG_CYC(10))
    dut (.*);
  ucd_port_model u_port (.i_clk(i_clk), .i_busy(o_busy),
    .i_probe(o_src_on | o_weak_pullup), .i_contact_en(contact_en),
    .i_code(code_r), .o_contact(i_contact_ok), .o_valid(i_type_valid),
    .o_type(i_type_code));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // settle past the edge so outputs are read after they land
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_addr <= 8'h09;
    i_wr_en <= 1'b0;
    tick(2);
  endtask
  // one run; dly keeps the contacts apart that many cycles
  task automatic run(input logic [7:0] ctl, input logic [3:0] code,
                     input int dly, input bit bus);
    i_usb_compliant_sel <= 1'($urandom);
    i_data_pos_switch_req <= 1'($urandom);
    i_data_neg_switch_req <= 1'($urandom);
    code_r <= code;
    contact_en <= (dly == 0);
    tick(1);
    expq.push_back({code, code == 4'h0 || code == 4'h1 && i_usb_compliant_sel,
                    i_data_pos_switch_req, i_data_neg_switch_req, 1'b0});
    if (bus) i_bus_valid <= 1'b1;
    else wr(8'h09, ctl);
    if (!bus) chk(o_rdata[1], 1'b1);
    tick(dly);
    if (dly) chk({o_busy, flag}, {ctl[2] & !ctl[3], ctl[2]});
    contact_en <= 1'b1;
    for (int n = 0; n < 400 && (o_busy || n < 6); n++) @(posedge i_clk);
    tick(3);
    chk(o_busy, 1'b0);
  endtask
  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a finished run is compared with the oldest noted outcome
  always @(negedge o_busy) begin
    if (i_reset_n === 1'b1) begin
      tick(2);
      chk(res, expq.pop_front());
    end
  end
  initial begin
    {i_reset_n, i_wr_en, i_adc_always_on, i_bus_valid, contact_en} = 5'h0;
    {i_usb_compliant_sel, i_charger_enable_force, i_force_value} = 3'h0;
    {i_data_pos_switch_req, i_data_neg_switch_req, i_bus_above_det} = 3'h1;
    {i_addr, i_wdata, code_r} = {8'h09, 8'h00, 4'h0};
    void'($urandom(77));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    tick(1);
    chk(o_rdata, 8'h8d);
    chk({o_ce_n_out, o_short_test, o_ce_n_oe_n, o_adc_on, o_busy},
        8'h4);
    foreach (codes[i]) run({2'b10, 2'($urandom), 4'hf}, codes[i], 0, 1'b0);
    run(8'h8f, 4'h3, 60, 1'b0);
    run(8'h87, 4'h2, 60, 1'b0);
    run(8'h8b, 4'h1, 60, 1'b0);
    run(8'h00, 4'h7, 0, 1'b1);
    chk(o_adc_on, 1'b1);
    i_bus_valid <= 1'b0;
    tick(4);
    chk(o_adc_on, 1'b0);
    i_adc_always_on <= 1'b1;
    tick(2);
    chk(o_adc_on, 1'b1);
    for (int f = 0; f < 4; f++) begin
      wr(8'h09, {2'(f), 6'h0c});
      chk({o_ovp_closed, o_ovp_logic}, {f == 1, f > 1});
    end
    wr(8'h0a, 8'hff); // unmapped place must leave the register alone
    chk(o_rdata, 8'hcc);
    i_charger_enable_force <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      i_force_value <= v[0];
      tick(2);
      chk(o_ce_n_oe_n, !v[0]);
    end
    wr(8'h09, 8'h8e);
    chk(o_busy, 1'b0);
    conclude();
  end
  // hang guard, far beyond the expected run length
  initial begin
    #300us;
    mismatches++;
    conclude();
  end
endmodule // test_usb_charger_detect_control

// File: dv/ucd_ctrl_checker.sv
// assertion checker for the charger detect control ports
`timescale 1ns/1ps
module ucd_ctrl_checker #(
  parameter int DCD_TIMEOUT_CYC = 20 // contact detect limit in cycles
) (
  input wire logic i_clk, i_reset_n, i_wr_en, i_bus_valid, // control
  input wire logic i_adc_always_on, i_usb_compliant_sel, // config levels
  input wire logic i_charger_enable_force, i_force_value, // force levels
  input wire logic [7:0] i_addr, i_wdata, o_rdata, // register port
  input wire logic o_data_pos_switch, o_data_neg_switch, o_busy, // state
  input wire logic o_src_on, o_weak_pullup, o_adc_on, // analog drives
  input wire logic o_short_test, // short test phase
  input wire logic o_ovp_closed, o_ovp_logic, o_ce_n_oe_n, // switch, ce
  input wire logic o_contact_detect_timeout_flag, // timeout flag
  input wire logic [3:0] o_detected_port_type // last type
);
  logic [15:0] run_cnt_r, run_cnt_nxt;
  wire sel = i_addr == 8'h09;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // busy cycles; the timeout flag may not rise before the limit
  always_comb run_cnt_nxt = o_busy ? run_cnt_r + 16'h1 : 16'h0;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) run_cnt_r <= 16'h0;
    else run_cnt_r <= run_cnt_nxt;
  //////////////////////////////////////////////////////////////////////////
  a_switch_open_run: assert property (
    o_busy |-> !o_data_pos_switch && !o_data_neg_switch) else $error("sw");
  a_adc_on_policy: assert property (
    o_adc_on ? (i_adc_always_on || $past(i_bus_valid, 2)) : !i_adc_always_on)
    else $error("converter enable wrong");
  a_ovp_field_map: assert property (
    sel && $past(sel) && $stable(o_rdata) |-> o_ovp_logic == o_rdata[7]
    && (!o_ovp_closed || o_rdata[7:6] == 2'b01)) else $error("ovp wrong");
  a_ce_forced_drive: assert property (
    i_charger_enable_force && $past(i_charger_enable_force) &&
    $stable(i_force_value) |-> o_ce_n_oe_n == !i_force_value)
    else $error("forced ce wrong");
  a_ce_type_table: assert property (
    !i_charger_enable_force && $past(!i_charger_enable_force) && !o_busy &&
    $stable(i_usb_compliant_sel) && $stable(o_detected_port_type) |->
    o_ce_n_oe_n == (o_detected_port_type == 4'h0 ||
    o_detected_port_type == 4'h1 && i_usb_compliant_sel)) else $error("ce");
  a_method_pick: assert property (
    sel && (o_src_on || o_weak_pullup) |-> o_weak_pullup == o_rdata[5] &&
    o_src_on != o_weak_pullup) else $error("probe method wrong");
  a_timeout_late: assert property (
    $rose(o_contact_detect_timeout_flag) |-> run_cnt_r >= DCD_TIMEOUT_CYC)
    else $error("timeout flag early");
  a_manual_start: assert property (
    i_wr_en && sel && i_wdata[1:0] == 2'b11 && !o_busy |-> ##[1:3] o_busy)
    else $error("manual start missed");
  a_short_then_probe: assert property (
    o_short_test |=> !o_short_test && (o_src_on || o_weak_pullup))
    else $error("short phase not one cycle");
endmodule // ucd_ctrl_checker
bind ucd_ctrl ucd_ctrl_checker #(.DCD_TIMEOUT_CYC(DCD_TIMEOUT_CYC)) u_chk (.*);

// File: dv/ucd_port_model.sv
// far-side port model: contacts and type answer
`timescale 1ns/1ps
module ucd_port_model (
  input wire logic i_clk, // system clock
  input wire logic i_busy, // detection running
  input wire logic i_probe, // source or pull-up applied
  input wire logic i_contact_en, // contacts mated
  input wire logic [3:0] i_code, // type this port presents
  output logic o_contact, // contact seen
  output logic o_valid, // type answer ready
  output logic [3:0] o_type // type answer
);
  logic seen_r = 1'b0;
  // answer once probed; held only for this run
  always @(posedge i_clk) seen_r <= i_busy & (seen_r | i_probe);
  assign o_contact = i_busy & i_contact_en;
  assign o_valid = seen_r;
  assign o_type = seen_r ? i_code : ~i_code; // no stale value when idle
endmodule // ucd_port_model

// File: hdl/ucd_ctrl.sv
// usb charger detection sequencer and control register
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - converter always-on clear: converter follows valid bus supply
// - converter always-on set: converter stays on; bit resets to zero
// - override field: 00 open, 01 closed above threshold, 10 logic
// - method bit picks source drive (0) or weak pull-up (1)
// - timer bit sets source-on time: 50 ms or 620 ms
// - contact detect enable requires contact pass before short test
// - contact detect running over 2 s sets the timeout flag
// - exit bit 1 leaves contact detect on timeout; 0 waits
// - manual bit starts detection, self-clears when sequence completes
// - charger detect enable bit gates detection; resets to one
// - sequence starts on bus supply becoming valid or manual bit
// - data switches open during sequence, follow the requests afterwards
// - charger-enable output reflects detected charger type
// - no charger inactive; standard port active only if not compliant
// - force bit overrides; forced value 1 pulls low, 0 releases
module ucd_ctrl #(
  parameter int DCD_TIMEOUT_CYC = ucd_pkg::UCD_DCD_TIMEOUT_CYC,
  parameter int SRC_SHORT_CYC = ucd_pkg::UCD_SRC_SHORT_CYC,
  parameter int SRC_LONG_CYC = ucd_pkg::UCD_SRC_LONG_CYC
) (
  input wire logic i_clk, // system clock 100 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_wr_en, // register write strobe
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  output logic [7:0] o_rdata, // register read data
  input wire logic i_adc_always_on, // converter always-on bit
  input wire logic i_usb_compliant_sel, // usb compliant bit
  input wire logic i_charger_enable_force, // force charger-enable
  input wire logic i_force_value, // forced value of charger-enable
  input wire logic i_bus_valid, // bus supply valid (pin)
  input wire logic i_bus_above_det, // bus above bus_detect_threshold (pin)
  input wire logic i_contact_ok, // data contact detected (pin)
  input wire logic i_type_valid, // analog type result ready (pin)
  input wire logic [3:0] i_type_code, // analog type result
  input wire logic i_data_pos_switch_req, // switch state requested
  input wire logic i_data_neg_switch_req, // switch state requested
  output logic o_data_pos_switch, // data positive switch closed
  output logic o_data_neg_switch, // data negative switch closed
  output logic o_src_on, // data positive source applied
  output logic o_weak_pullup, // weak pull-up applied in source phase
  output logic o_short_test, // short detection phase active
  output logic o_adc_on, // measurement converter enable
  output logic o_ovp_closed, // protection switch closed
  output logic o_ovp_logic, // protection switch left to logic
  output logic o_ce_n_out, // charger-enable low drive, 0 = drive
  output logic o_ce_n_oe_n, // charger-enable enable, 0 = drive
  output logic o_busy, // detection sequence running
  output logic [3:0] o_detected_port_type, // last detected type
  output logic o_contact_detect_timeout_flag // contact detect timed out
);
  import ucd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // synchronise pin levels
  logic bus_valid_s;
  logic above_s;
  logic contact_s;
  logic type_valid_s;
  ucd_sync u_sync_bus (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_d(i_bus_valid), .o_q(bus_valid_s));
  ucd_sync u_sync_above (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_d(i_bus_above_det), .o_q(above_s));
  ucd_sync u_sync_contact (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_d(i_contact_ok), .o_q(contact_s));
  ucd_sync u_sync_tv (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_d(i_type_valid), .o_q(type_valid_s));

  //////////////////////////////////////////////////////////////////////////
  // state and decode
  ucd_state_t state_r;
  ucd_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [UCD_CNT_W-1:0] cnt_r;
  logic [UCD_CNT_W-1:0] cnt_nxt;
  logic bus_prev_r;
  logic bus_prev_nxt;
  logic timeout_r;
  logic timeout_nxt;
  logic man_run_r;
  logic man_run_nxt;
  logic pos_save_r;
  logic pos_save_nxt;
  logic neg_save_r;
  logic neg_save_nxt;
  logic [3:0] type_r;
  logic [3:0] type_nxt;
  logic wr_hit;
  logic bus_rise;
  logic start;
  logic launch;
  logic dcd_exit;
  logic dcd_at_limit;
  logic src_at_end;
  logic take_result;
  logic seq_done;
  logic [UCD_CNT_W-1:0] src_len;
  logic [1:0] ovp_field;
  logic ce_active;

  // decode of the current state and configuration
  assign wr_hit = i_wr_en && (i_addr == UCD_DET_CTRL_ADDR);
  assign bus_rise = bus_valid_s && !bus_prev_r;
  // rising bus supply or manual request starts, gated by detect enable
  assign start = ctrl_r[UCD_DET_EN_BIT] &&
    (bus_rise || ctrl_r[UCD_MAN_BIT]);
  assign launch = (state_r == UCD_IDLE) && start;
  // a bus edge seen while busy is dropped; the running pass covers it
  assign dcd_exit = contact_s ||
    (timeout_r && ctrl_r[UCD_EXIT_BIT]);
  assign dcd_at_limit = (cnt_r >= UCD_CNT_W'(DCD_TIMEOUT_CYC));
  assign src_len = ctrl_r[UCD_TIMER_BIT] ?
    UCD_CNT_W'(SRC_LONG_CYC) : UCD_CNT_W'(SRC_SHORT_CYC);
  assign src_at_end = (cnt_r >= src_len);
  // type code latches only a synchronised valid, so the data bus is stable
  assign take_result = (state_r == UCD_SRC) && src_at_end && type_valid_s;
  assign seq_done = (state_r == UCD_DONE);

  //////////////////////////////////////////////////////////////////////////
  // control register
  // completion is applied after a write so the self-clear always wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_hit) begin
      ctrl_nxt = i_wdata;
      // a running software sequence keeps reading one
      if (man_run_r) begin
        ctrl_nxt[UCD_MAN_BIT] = 1'b1;
      end
    end
    if (seq_done) begin
      ctrl_nxt[UCD_MAN_BIT] = 1'b0;
    end
  end

  // control register flops; reset leaves detection enabled
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r <= UCD_DET_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus supply history for the start edge
  // reset low matches an absent supply, so no false edge after reset
  always_comb begin
    bus_prev_nxt = bus_valid_s;
  end

  // bus history flop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_prev_r <= 1'b0;
    end else begin
      bus_prev_r <= bus_prev_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  // next state of the detection pass
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UCD_IDLE: begin
        if (launch) begin
          // contact phase first only when it is enabled
          if (ctrl_r[UCD_CONTACT_DETECT_ENABLE_BIT]) begin
            state_nxt = UCD_DCD;
          end else begin
            state_nxt = UCD_SHORT;
          end
        end
      end
      UCD_DCD: begin
        if (dcd_exit) begin
          state_nxt = UCD_SHORT;
        end
      end
      UCD_SHORT: begin
        state_nxt = UCD_SRC;
      end
      UCD_SRC: begin
        // source held for the selected time, then result taken
        if (take_result) begin
          state_nxt = UCD_DONE;
        end
      end
      UCD_DONE: begin
        state_nxt = UCD_IDLE;
      end
      default: begin
        state_nxt = UCD_IDLE;
      end
    endcase
  end

  // sequencer state flop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= UCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // phase counter
  // one counter serves both timed phases; it saturates rather than wraps
  always_comb begin
    cnt_nxt = '0;
    case (state_r)
      UCD_DCD: begin
        if (dcd_exit) begin
          cnt_nxt = '0;
        end else if (!dcd_at_limit) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = cnt_r;
        end
      end
      UCD_SRC: begin
        if (!src_at_end) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = cnt_r;
        end
      end
      default: begin
        cnt_nxt = '0;
      end
    endcase
  end

  // phase counter flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // contact timeout flag
  // cleared only by a new pass so software can read why the last one left
  always_comb begin
    timeout_nxt = timeout_r;
    if (launch) begin
      timeout_nxt = 1'b0;
    end else if ((state_r == UCD_DCD) && dcd_at_limit) begin
      timeout_nxt = 1'b1;
    end
  end

  // timeout flag flop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= timeout_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // run context: who started the pass, switch states, result
  always_comb begin
    man_run_nxt = man_run_r;
    pos_save_nxt = pos_save_r;
    neg_save_nxt = neg_save_r;
    type_nxt = type_r;
    if (launch) begin
      man_run_nxt = ctrl_r[UCD_MAN_BIT];
      pos_save_nxt = i_data_pos_switch_req;
      neg_save_nxt = i_data_neg_switch_req;
    end
    if (take_result) begin
      type_nxt = i_type_code;
    end
    if (seq_done) begin
      man_run_nxt = 1'b0;
    end
  end

  // run context flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      man_run_r <= 1'b0;
      pos_save_r <= 1'b0;
      neg_save_r <= 1'b0;
      type_r <= UCD_TYPE_NONE;
    end else begin
      man_run_r <= man_run_nxt;
      pos_save_r <= pos_save_nxt;
      neg_save_r <= neg_save_nxt;
      type_r <= type_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_busy = (state_r != UCD_IDLE);
  assign o_rdata = (i_addr == UCD_DET_CTRL_ADDR) ? ctrl_r : 8'h00;
  // switches open for the whole sequence, requested state otherwise
  assign o_data_pos_switch = o_busy ? 1'b0 :
    (man_run_r ? pos_save_r : i_data_pos_switch_req);
  assign o_data_neg_switch = o_busy ? 1'b0 :
    (man_run_r ? neg_save_r : i_data_neg_switch_req);
  // probe drive follows the method bit only inside the source phase
  assign o_src_on = (state_r == UCD_SRC) &&
    !ctrl_r[UCD_METHOD_BIT];
  assign o_weak_pullup = (state_r == UCD_SRC) &&
    ctrl_r[UCD_METHOD_BIT];
  assign o_short_test = (state_r == UCD_SHORT);
  assign o_adc_on = i_adc_always_on || bus_valid_s;
  // reserved override code treated as logic control
  assign ovp_field = ctrl_r[UCD_OVP_MSB:UCD_OVP_LSB];
  assign o_ovp_closed = (ovp_field == UCD_OVP_CLOSED) && above_s;
  assign o_ovp_logic = (ovp_field == UCD_OVP_LOGIC) ||
    (ovp_field == 2'b11);
  assign ce_active = (type_r == UCD_TYPE_NONE) ? 1'b0 :
    (type_r == UCD_TYPE_SDP) ? !i_usb_compliant_sel : 1'b1;
  // open drain only ever pulls low; the enable carries the level
  assign o_ce_n_out = 1'b0;
  assign o_ce_n_oe_n = i_charger_enable_force ? !i_force_value :
    !ce_active;
  assign o_detected_port_type = type_r;
  assign o_contact_detect_timeout_flag = timeout_r;
endmodule // ucd_ctrl

// File: hdl/ucd_pkg.sv
// constants and types for the usb charger detect control block
package ucd_pkg;
  localparam logic [7:0] UCD_DET_CTRL_ADDR = 8'h09;
  localparam logic [7:0] UCD_DET_CTRL_RST = 8'h8d;
  localparam int UCD_OVP_MSB = 7;
  localparam int UCD_OVP_LSB = 6;
  localparam int UCD_METHOD_BIT = 5;
  localparam int UCD_TIMER_BIT = 4;
  localparam int UCD_EXIT_BIT = 3;
  localparam int UCD_CONTACT_DETECT_ENABLE_BIT = 2;
  localparam int UCD_MAN_BIT = 1;
  localparam int UCD_DET_EN_BIT = 0;
  localparam logic [1:0] UCD_OVP_OPEN = 2'b00;
  localparam logic [1:0] UCD_OVP_CLOSED = 2'b01;
  localparam logic [1:0] UCD_OVP_LOGIC = 2'b10;
  localparam int UCD_CLK_MHZ = 100;
  localparam int UCD_DCD_TIMEOUT_MS = 2000;
  localparam int UCD_SRC_SHORT_MS = 50;
  localparam int UCD_SRC_LONG_MS = 620;
  localparam int UCD_DCD_TIMEOUT_CYC = UCD_DCD_TIMEOUT_MS * 1000 * UCD_CLK_MHZ;
  localparam int UCD_SRC_SHORT_CYC = UCD_SRC_SHORT_MS * 1000 * UCD_CLK_MHZ;
  localparam int UCD_SRC_LONG_CYC = UCD_SRC_LONG_MS * 1000 * UCD_CLK_MHZ;
  localparam int UCD_CNT_W = 28;
  localparam logic [3:0] UCD_TYPE_NONE = 4'h0;
  localparam logic [3:0] UCD_TYPE_SDP = 4'h1;
  typedef enum logic [2:0] {
    UCD_IDLE, UCD_DCD, UCD_SHORT, UCD_SRC, UCD_DONE
  } ucd_state_t;
endpackage

// File: hdl/ucd_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module ucd_sync (
  input wire logic i_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_d, // asynchronous level
  output logic o_q // synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;
  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = i_d;
    q_nxt = meta_r;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      o_q <= q_nxt;
    end
  end
endmodule // ucd_sync
